//--- qpc_pkg.sv
// Shared constants and types of the quadrature phase counter.
// Assumes one 100 MHz core clock and a synchronous active-low reset.
package qpc_pkg;

    localparam int NCH = 2;
    localparam int CW = 16;
    localparam int AW = 8;
    localparam int DW = 16;

    // Per-channel register offsets, channel index sits in addr[7:4]
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_MODE = 4'h1;
    localparam logic [3:0] OFS_IO = 4'h2;
    localparam logic [3:0] OFS_IER = 4'h3;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_CNT = 4'h5;
    localparam logic [3:0] OFS_GCR = 4'h6;

    // timer_control_reg fields
    localparam int PSC_LSB = 0;
    localparam int CLOCK_EDGE_SELECT_LSB = 3;
    localparam int COUNTER_CLEAR_SELECT_LSB = 5;
    localparam logic [2:0] COUNTER_CLEAR_SELECT_NONE = 3'h0;
    localparam logic [2:0] COUNTER_CLEAR_SELECT_MATCH = 3'h1;

    // Mode register fields
    localparam int PHASE_EN_BIT = 0;
    localparam int SUB_LSB = 1;

    // io_control_reg, interrupt_enable_reg and timer_status_reg fields
    localparam int IO_CAPTURE_BIT = 0;
    localparam int IEN_MATCH_BIT = 0;
    localparam int IEN_OVF_BIT = 4;
    localparam int IEN_UNF_BIT = 5;
    localparam int ST_MATCH_BIT = 0;
    localparam int ST_OVF_BIT = 4;
    localparam int ST_UNF_BIT = 5;
    localparam int ST_DIR_BIT = 7;

    // Reset values and the counter maximum
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [CW-1:0] CNT_RST = 16'h0000;
    localparam logic [CW-1:0] GCR_RST = 16'hFFFF;
    localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        SUB_MODE1 = 2'b00,
        SUB_MODE2 = 2'b01,
        SUB_MODE3 = 2'b10,
        SUB_MODE4 = 2'b11
    } qpc_submode_type;

    typedef struct packed {
        logic up;
        logic dn;
    } qpc_step_type;

    function automatic logic reg_hit(input logic [AW-1:0] addr,
                                     input int ch, input logic [3:0] ofs);
        reg_hit = (addr[7:4] == 4'(ch)) && (addr[3:0] == ofs);
    endfunction

    // Internal tick: divide by 1, 4, 16 or 64; codes above 3 divide by 64
    function automatic logic psc_tick(input logic [2:0] psc,
                                      input logic [5:0] div);
        case (psc)
            3'h0: psc_tick = 1'b1;
            3'h1: psc_tick = (div[1:0] == 2'h0);
            3'h2: psc_tick = (div[3:0] == 4'h0);
            default: psc_tick = (div == 6'h00);
        endcase
    endfunction

endpackage

//--- qpc_phase_dec.sv
// Phase decoder: turns two encoder phases into up/down count steps.
// Assumes phases may be asynchronous; they are synchronised here.
`timescale 1ns/100ps
module qpc_phase_dec
    import qpc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Encoder phases and selected sub-mode
    input wire logic phase_a,
    input wire logic phase_b,
    input wire qpc_submode_type submode,
    // Count step for this clock
    output qpc_step_type step
);
    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    logic a_prev_q;
    logic b_prev_q;
    logic a_lvl;
    logic b_lvl;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic a_edge;
    logic b_edge;

    // Two flops per phase, then one more sample to find edges
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end else begin
            a_sync_q <= {a_sync_q[0], phase_a};
            b_sync_q <= {b_sync_q[0], phase_b};
            a_prev_q <= a_sync_q[1];
            b_prev_q <= b_sync_q[1];
        end
    end

    assign a_lvl = a_sync_q[1];
    assign b_lvl = b_sync_q[1];
    assign a_rise = a_lvl & ~a_prev_q;
    assign a_fall = ~a_lvl & a_prev_q;
    assign b_rise = b_lvl & ~b_prev_q;
    assign b_fall = ~b_lvl & b_prev_q;
    // Both phases moving at once carries no direction, so it is dropped
    assign a_edge = (a_rise | a_fall) & ~(b_rise | b_fall);
    assign b_edge = (b_rise | b_fall) & ~(a_rise | a_fall);

    always_comb begin
        step = '0;
        case (submode)
            SUB_MODE1: begin
                step.up = (b_edge & b_rise & a_lvl)
                        | (b_edge & b_fall & ~a_lvl)
                        | (a_edge & a_rise & ~b_lvl)
                        | (a_edge & a_fall & b_lvl);
                step.dn = (b_edge & b_fall & a_lvl)
                        | (b_edge & b_rise & ~a_lvl)
                        | (a_edge & a_rise & b_lvl)
                        | (a_edge & a_fall & ~b_lvl);
            end
            SUB_MODE2: begin
                step.up = a_edge & a_fall & b_lvl;
                step.dn = a_edge & a_fall & ~b_lvl;
            end
            SUB_MODE3: begin
                step.up = a_edge & a_fall & b_lvl;
                step.dn = b_edge & b_fall & a_lvl;
            end
            SUB_MODE4: begin
                step.up = b_edge & (b_rise ? a_lvl : ~a_lvl);
                step.dn = b_edge & (b_rise ? ~a_lvl : a_lvl);
            end
            default: step = '0;
        endcase
    end

    a_step_single: assert property (@(posedge core_clk) disable iff (!nrst)
        !(step.up && step.dn)) else $error("up and down in one clock");
    a_step_cause: assert property (@(posedge core_clk) disable iff (!nrst)
        (step.up || step.dn) |-> (a_lvl != $past(a_lvl)) ||
        (b_lvl != $past(b_lvl))) else $error("step without edge");
    a_mode4_a_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        submode == SUB_MODE4 && a_edge |-> !step.up && !step.dn)
        else $error("A edge counted in sub-mode 4");
    a_mode2_b_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        submode == SUB_MODE2 && b_edge |-> !step.up && !step.dn)
        else $error("B edge counted in sub-mode 2");
endmodule

//--- qpc_top.sv
// Two-channel timer with quadrature phase counting, capture and compare.
// Assumes a plain register port and encoder pins sampled on core_clk.
`timescale 1ns/100ps
module qpc_top
    import qpc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Encoder phase pins
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    // Capture inputs and compare outputs, one per channel
    input wire logic [NCH-1:0] capture_in,
    output logic [NCH-1:0] compare_out,
    // Interrupt requests, one per channel
    output logic [NCH-1:0] overflow_irq,
    output logic [NCH-1:0] underflow_irq,
    output logic [NCH-1:0] match_irq
);
    logic [NCH-1:0][7:0] ctrl_q;
    logic [NCH-1:0][2:0] mode_q;
    logic [NCH-1:0] io_q;
    logic [NCH-1:0][7:0] ier_q;
    logic [NCH-1:0][CW-1:0] cnt_q;
    logic [NCH-1:0][CW-1:0] cnt_d;
    logic [NCH-1:0][CW-1:0] gcr_q;
    logic [NCH-1:0] ovf_q;
    logic [NCH-1:0] unf_q;
    logic [NCH-1:0] match_q;
    logic [NCH-1:0] dir_q;
    logic [NCH-1:0] cap_prev_q;
    logic [NCH-1:0] cmp_q;
    logic [5:0] div_q;
    logic [DW-1:0] rdata_q;
    logic [NCH-1:0] phase_a;
    logic [NCH-1:0] phase_b;
    qpc_step_type [NCH-1:0] step;
    logic [NCH-1:0] phase_en;
    logic [NCH-1:0] up_ev;
    logic [NCH-1:0] dn_ev;
    logic [NCH-1:0] ovf_ev;
    logic [NCH-1:0] unf_ev;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] hit_ev;
    logic [NCH-1:0] clr_ev;
    logic [NCH-1:0] cnt_wr;

    // Only these two channels have phase inputs
    assign phase_a[0] = ext_clock_in_a;
    assign phase_b[0] = ext_clock_in_b;
    assign phase_a[1] = ext_clock_in_c;
    assign phase_b[1] = ext_clock_in_d;

    for (genvar g = 0; g < NCH; g++) begin : g_dec
        qpc_phase_dec u_dec (
            .core_clk(core_clk),
            .nrst(nrst),
            .phase_a(phase_a[g]),
            .phase_b(phase_b[g]),
            .submode(qpc_submode_type'(mode_q[g][SUB_LSB+:2])),
            .step(step[g])
        );
    end

    // Free-running divider for the internal count source
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    // Count source, wrap, capture, compare and clear
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            phase_en[c] = mode_q[c][PHASE_EN_BIT];
            if (phase_en[c]) begin
                up_ev[c] = step[c].up;
                dn_ev[c] = step[c].dn;
            end else begin
                up_ev[c] = psc_tick(ctrl_q[c][PSC_LSB+:3], div_q);
                dn_ev[c] = 1'b0;
            end
            cnt_wr[c] = reg_wr && reg_hit(reg_addr, c, OFS_CNT);
            ovf_ev[c] = up_ev[c] && (cnt_q[c] == CNT_MAX);
            unf_ev[c] = dn_ev[c] && (cnt_q[c] == CNT_RST);
            cap_ev[c] = io_q[c] && capture_in[c] && !cap_prev_q[c];
            if (up_ev[c]) begin
                cnt_d[c] = cnt_q[c] + 16'h0001;
            end else if (dn_ev[c]) begin
                cnt_d[c] = cnt_q[c] - 16'h0001;
            end else begin
                cnt_d[c] = cnt_q[c];
            end
            hit_ev[c] = !io_q[c] && (up_ev[c] || dn_ev[c])
                && (cnt_d[c] == gcr_q[c]);
            clr_ev[c] = (ctrl_q[c][COUNTER_CLEAR_SELECT_LSB+:3] == COUNTER_CLEAR_SELECT_MATCH)
                && (hit_ev[c] || cap_ev[c]);
        end
    end

    // Counter: a software write beats a clear, a clear beats a step
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (!nrst) begin
                cnt_q[c] <= CNT_RST;
            end else if (cnt_wr[c]) begin
                cnt_q[c] <= reg_wdata;
            end else if (clr_ev[c]) begin
                cnt_q[c] <= CNT_RST;
            end else begin
                cnt_q[c] <= cnt_d[c];
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (!nrst) begin
                ctrl_q[c] <= CTRL_RST;
                mode_q[c] <= MODE_RST;
                io_q[c] <= 1'b0;
                ier_q[c] <= IER_RST;
            end else if (reg_wr) begin
                if (reg_hit(reg_addr, c, OFS_CTRL)) begin
                    ctrl_q[c] <= reg_wdata[7:0];
                end else if (reg_hit(reg_addr, c, OFS_MODE)) begin
                    mode_q[c] <= reg_wdata[2:0];
                end else if (reg_hit(reg_addr, c, OFS_IO)) begin
                    io_q[c] <= reg_wdata[IO_CAPTURE_BIT];
                end else if (reg_hit(reg_addr, c, OFS_IER)) begin
                    ier_q[c] <= reg_wdata[7:0];
                end
            end
        end
    end

    // Compare/capture register; a capture wins over a software write
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (!nrst) begin
                gcr_q[c] <= GCR_RST;
                cap_prev_q[c] <= 1'b0;
                cmp_q[c] <= 1'b0;
            end else begin
                cap_prev_q[c] <= capture_in[c];
                if (cap_ev[c]) begin
                    gcr_q[c] <= cnt_q[c];
                end else if (reg_wr && reg_hit(reg_addr, c, OFS_GCR)) begin
                    gcr_q[c] <= reg_wdata;
                end
                if (hit_ev[c]) begin
                    cmp_q[c] <= ~cmp_q[c];
                end
            end
        end
    end

    // Sticky flags, write 1 to clear; a new event beats the clear; dir_q follows the last step
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (!nrst) begin
                ovf_q[c] <= 1'b0;
                unf_q[c] <= 1'b0;
                match_q[c] <= 1'b0;
                dir_q[c] <= 1'b0;
            end else begin
                if (ovf_ev[c]) begin
                    ovf_q[c] <= 1'b1;
                end else if (reg_wr && reg_hit(reg_addr, c, OFS_STAT)
                             && reg_wdata[ST_OVF_BIT]) begin
                    ovf_q[c] <= 1'b0;
                end
                if (unf_ev[c]) begin
                    unf_q[c] <= 1'b1;
                end else if (reg_wr && reg_hit(reg_addr, c, OFS_STAT)
                             && reg_wdata[ST_UNF_BIT]) begin
                    unf_q[c] <= 1'b0;
                end
                if (hit_ev[c] || cap_ev[c]) begin
                    match_q[c] <= 1'b1;
                end else if (reg_wr && reg_hit(reg_addr, c, OFS_STAT)
                             && reg_wdata[ST_MATCH_BIT]) begin
                    match_q[c] <= 1'b0;
                end
                if (up_ev[c]) begin
                    dir_q[c] <= 1'b1;
                end else if (dn_ev[c]) begin
                    dir_q[c] <= 1'b0;
                end
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst || !reg_rd) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= 16'h0000;
            for (int c = 0; c < NCH; c++) begin
                if (reg_hit(reg_addr, c, OFS_CTRL)) begin
                    rdata_q <= {8'h00, ctrl_q[c]};
                end else if (reg_hit(reg_addr, c, OFS_MODE)) begin
                    rdata_q <= {13'h0000, mode_q[c]};
                end else if (reg_hit(reg_addr, c, OFS_IO)) begin
                    rdata_q <= {15'h0000, io_q[c]};
                end else if (reg_hit(reg_addr, c, OFS_IER)) begin
                    rdata_q <= {8'h00, ier_q[c]};
                end else if (reg_hit(reg_addr, c, OFS_STAT)) begin
                    rdata_q <= {8'h00, dir_q[c], 1'b0, unf_q[c], ovf_q[c],
                                3'h0, match_q[c]};
                end else if (reg_hit(reg_addr, c, OFS_CNT)) begin
                    rdata_q <= cnt_q[c];
                end else if (reg_hit(reg_addr, c, OFS_GCR)) begin
                    rdata_q <= gcr_q[c];
                end
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign compare_out = cmp_q;

    // Requests are levels so software sees them until the flag or its enable bit is cleared
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            overflow_irq[c] = ovf_q[c] && ier_q[c][IEN_OVF_BIT];
            underflow_irq[c] = unf_q[c] && ier_q[c][IEN_UNF_BIT];
            match_irq[c] = match_q[c] && ier_q[c][IEN_MATCH_BIT];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_ovf_wrap: assert property (
            ovf_ev[g] && !cnt_wr[g] && !clr_ev[g] |=> cnt_q[g] == 16'h0000
            && ovf_q[g]) else $error("overflow did not wrap");
        a_unf_wrap: assert property (
            unf_ev[g] && !cnt_wr[g] && !clr_ev[g] |=> cnt_q[g] == 16'hFFFF
            && unf_q[g]) else $error("underflow did not wrap");
        a_ovf_request: assert property (
            ovf_ev[g] && ier_q[g][IEN_OVF_BIT] && !reg_wr |=> overflow_irq[g])
            else $error("overflow request missing");
        a_unf_request: assert property (
            unf_ev[g] && ier_q[g][IEN_UNF_BIT] && !reg_wr |=> underflow_irq[g])
            else $error("underflow request missing");
        a_psc_ignored: assert property (
            phase_en[g] && !step[g].up && !step[g].dn && !cnt_wr[g]
            && !clr_ev[g] |=> cnt_q[g] == $past(cnt_q[g]))
            else $error("counter moved without phase step");
        a_dir_follow: assert property (
            phase_en[g] && step[g].dn |=> !dir_q[g] ##0
            (cnt_q[g] == $past(cnt_q[g]) - 16'h0001 || $past(clr_ev[g])
            || $past(cnt_wr[g]))) else $error("down step not reflected");
        a_capture_load: assert property (
            cap_ev[g] |=> gcr_q[g] == $past(cnt_q[g]) && match_q[g])
            else $error("capture did not load");
        a_clear_hit: assert property (
            hit_ev[g] && ctrl_q[g][COUNTER_CLEAR_SELECT_LSB+:3] == COUNTER_CLEAR_SELECT_MATCH && !cnt_wr[g]
            |=> cnt_q[g] == 16'h0000) else $error("match did not clear");
    end

    a_read_once: assert property (
        !reg_rd |=> reg_rdata == 16'h0000) else $error("stale read data");
endmodule

//--- qpc_encoder_model.sv
// Two-phase encoder model driving one pair of phase pins.
// Assumes the bench calls put; pins move just after a rising edge.
`timescale 1ns/100ps
module qpc_encoder_model (
    // Clock
    input wire logic core_clk,
    // Phase pins, always driven like a push-pull encoder
    output logic pha,
    output logic phb
);
    initial begin
        pha = 1'b0;
        phb = 1'b0;
    end

    // Both phases at one edge; moving both at once is a refused case
    task automatic put(input logic a, input logic b);
        @(posedge core_clk);
        pha <= a;
        phb <= b;
    endtask
endmodule

//--- tb_qpc_top.sv
// Bench for the two-channel quadrature phase counter.
// Assumes one encoder model per channel and the plain register port.
`timescale 1ns/100ps
module tb_qpc_top import qpc_pkg::*; ;
    logic core_clk;
    logic nrst;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DW-1:0] reg_rdata;
    logic ext_a, ext_b, ext_c, ext_d;
    logic [NCH-1:0] capture_in;
    logic [NCH-1:0] compare_out, overflow_irq, underflow_irq, match_irq;
    int miscompares;
    int total_checks;
    logic [DW-1:0] rv;
    // Edge kinds 0..7: pre-state of A and B, and which phase then moves
    localparam logic [7:0] PRE_A = 8'h99;
    localparam logic [7:0] PRE_B = 8'h5A;
    localparam logic [7:0] TOG_A = 8'hCC;
    localparam logic [7:0] UP_M [4] = '{8'h0F, 8'h08, 8'h08, 8'h03};
    localparam logic [7:0] DN_M [4] = '{8'hF0, 8'h80, 8'h10, 8'h30};

    qpc_top qpc_top_i (.core_clk(core_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_in_a(ext_a),
        .ext_clock_in_b(ext_b), .ext_clock_in_c(ext_c),
        .ext_clock_in_d(ext_d), .capture_in(capture_in),
        .compare_out(compare_out), .overflow_irq(overflow_irq),
        .underflow_irq(underflow_irq), .match_irq(match_irq));
    qpc_encoder_model enc0 (.core_clk(core_clk), .pha(ext_a), .phb(ext_b));
    qpc_encoder_model enc1 (.core_clk(core_clk), .pha(ext_c), .phb(ext_d));

    task automatic chk(input string what, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Edge, then 1 ns so the edge's updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input int ch, input logic [3:0] ofs,
                      input logic [DW-1:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= {4'(ch), ofs};
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input int ch, input logic [3:0] ofs);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= {4'(ch), ofs};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task automatic enc(input int ch, input logic a, input logic b);
        if (ch == 0) begin
            enc0.put(a, b);
        end else begin
            enc1.put(a, b);
        end
    endtask

    task automatic test_reset();
        rd(0, OFS_GCR);
        chk("gcr reset", rv, GCR_RST);
        cyc(1);
        chk("rdata idle", reg_rdata, 16'h0000);
        rd(1, OFS_IER);
        chk("ier reset", rv, 16'(IER_RST));
        rd(1, OFS_STAT);
        chk("flags reset", rv & 16'h0031, 16'h0000);
        wr(0, 4'hF, 16'h1234);
        rd(0, 4'hF);
        chk("unmapped", rv, 16'h0000);
    endtask

    // Fastest prescaler and odd edge select stay set: a leak would count
    task automatic test_table();
        logic [DW-1:0] exp;
        logic a0;
        logic b0;
        for (int ch = 0; ch < NCH; ch++) begin
            for (int m = 0; m < 4; m++) begin
                for (int o = 0; o < NCH; o++) begin
                    wr(o, OFS_CTRL, 16'h0018);
                    wr(o, OFS_MODE, 16'(2 * m + 1));
                end
                for (int k = 0; k < 8; k++) begin
                    a0 = PRE_A[k];
                    b0 = PRE_B[k];
                    enc(ch, a0, b0);
                    cyc(5);
                    wr(0, OFS_CNT, 16'h0100);
                    wr(1, OFS_CNT, 16'h0100);
                    enc(ch, a0 ^ TOG_A[k], b0 ^ ~TOG_A[k]);
                    cyc(5);
                    exp = 16'h0100 + 16'(UP_M[m][k]) - 16'(DN_M[m][k]);
                    rd(ch, OFS_CNT);
                    chk("count", rv, exp);
                    rd(1 - ch, OFS_CNT);
                    chk("other", rv, 16'h0100);
                    if ((UP_M[m][k] | DN_M[m][k]) == 1'b1) begin
                        rd(ch, OFS_STAT);
                        chk("dir", 16'(rv[7]), 16'(UP_M[m][k]));
                    end
                end
            end
        end
    endtask

    task automatic test_edges();
        wr(0, OFS_MODE, 16'h0007);
        enc(0, 1'b0, 1'b0);
        cyc(5);
        wr(0, OFS_CNT, 16'h0100);
        cyc(20);
        rd(0, OFS_CNT);
        chk("idle pins", rv, 16'h0100);
        enc(0, 1'b1, 1'b1);
        cyc(5);
        rd(0, OFS_CNT);
        chk("both moved", rv, 16'h0100);
        // Outside phase mode the prescaler counts: 64 clocks per read
        wr(1, OFS_MODE, 16'h0000);
        for (int p = 1; p < 4; p++) begin
            wr(1, OFS_CTRL, 16'(p));
            wr(1, OFS_CNT, 16'h0000);
            cyc(63);
            rd(1, OFS_CNT);
            chk("prescaled", rv, 16'(64 >> (2 * p)));
        end
    endtask

    task automatic test_wrap();
        wr(0, OFS_IER, 16'h0030);
        enc(0, 1'b1, 1'b0);
        cyc(5);
        wr(0, OFS_CNT, CNT_MAX);
        enc(0, 1'b1, 1'b1);
        cyc(5);
        rd(0, OFS_CNT);
        chk("wrap up", rv, 16'h0000);
        chk("ovf irq", 16'(overflow_irq), 16'h0001);
        chk("unf idle", 16'(underflow_irq), 16'h0000);
        wr(0, OFS_STAT, 16'h0010);
        cyc(1);
        chk("ovf clear", 16'(overflow_irq), 16'h0000);
        enc(0, 1'b1, 1'b0);
        cyc(5);
        rd(0, OFS_CNT);
        chk("wrap down", rv, CNT_MAX);
        chk("unf irq", 16'(underflow_irq), 16'h0001);
        chk("hit at max", 16'(compare_out), 16'h0001);
        wr(0, OFS_IER, 16'h0000);
        cyc(1);
        chk("unf masked", 16'(underflow_irq), 16'h0000);
        rd(0, OFS_STAT);
        chk("flags", rv & 16'h00B0, 16'h0020);
        wr(0, OFS_STAT, 16'h0030);
    endtask

    task automatic test_cmp();
        wr(1, OFS_CTRL, 16'h0020);
        wr(1, OFS_MODE, 16'h0007);
        wr(1, OFS_IER, 16'h0001);
        enc(1, 1'b1, 1'b0);
        cyc(5);
        wr(1, OFS_GCR, 16'h0101);
        wr(1, OFS_CNT, 16'h0100);
        enc(1, 1'b1, 1'b1);
        cyc(5);
        rd(1, OFS_CNT);
        chk("match clear", rv, 16'h0000);
        chk("match irq", 16'(match_irq), 16'h0002);
        chk("compare out", 16'(compare_out), 16'h0003);
        wr(1, OFS_IO, 16'h0001);
        wr(1, OFS_CNT, 16'h0042);
        @(posedge core_clk);
        capture_in <= 2'b10;
        cyc(3);
        @(posedge core_clk);
        capture_in <= 2'b00;
        rd(1, OFS_GCR);
        chk("capture", rv, 16'h0042);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        nrst = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        capture_in = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        test_reset();
        test_table();
        test_edges();
        test_wrap();
        test_cmp();
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
endmodule
